// ---- dv/adc_mode_scan_control_test.sv ----
// Self-checking bench for the mode and scan control block
`timescale 1ns/100ps
module adc_mode_scan_control_test
  import amsc_pkg::*;
;
  localparam int REP = 8;
  logic        clk_sys, sys_rst, sclk, cs_n, din, dout, convert_start_pin_n;
  logic        conv_done, conv_start, conv_avg_allow, int_clock_mode;
  logic        tag_output_with_channel, software_convert_trigger, tg;
  logic [11:0] conv_result;
  logic [3:0]  conv_channel, scan_mode, channel_pick, ch, n, cch;
  logic [1:0]  power_state_select;
  logic [4:0]  fifo_count;
  logic [31:0] seed, r, t;
  logic [15:0] rd, w;
  logic [15:0] res_q[$];
  int          err_total, cmp_count;

  always #5 clk_sys = ~clk_sys;

  amsc_top #(.REPEAT_COUNT(REP)) amsc_top_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n), .din(din),
    .convert_start_pin_n(convert_start_pin_n), .conv_done(conv_done),
    .conv_result(conv_result), .dout(dout), .conv_start(conv_start),
    .conv_channel(conv_channel), .conv_avg_allow(conv_avg_allow),
    .int_clock_mode(int_clock_mode), .power_state_select(power_state_select),
    .tag_output_with_channel(tag_output_with_channel),
    .software_convert_trigger(software_convert_trigger), .scan_mode(scan_mode),
    .channel_pick(channel_pick), .fifo_count(fifo_count));
  amsc_host_model amsc_host_model_i (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function logic [15:0] mode_word(input logic [3:0] sc, input logic [3:0] c,
                                  input logic [1:0] rs, input logic [1:0] pm,
                                  input logic tag, input logic sw);
    return {1'b0, sc, c, rs, pm, tag, sw, 1'b0};
  endfunction
  function logic [15:0] out_word(input logic tag, input logic [15:0] e);
    return tag ? e : {e[11:0], 4'h0};
  endfunction
  task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task wrap_up();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task wait_fifo(input logic [4:0] c);
    int k;
    k = 0;
    while (fifo_count !== c && k < 3000) begin
      @(posedge clk_sys);
      k++;
    end
    if (k == 3000) begin
      err_total++;
      $display("CHECK FAILED t=%0t fifo count never reached", $time);
      wrap_up();
    end
  endtask
  task fr(input logic [15:0] word);
    amsc_host_model_i.frame(word, rd);
  endtask

  // Converter core stand-in: answers each start a few cycles later
  always @(posedge clk_sys) begin
    if (conv_start === 1'b1) begin
      cch = conv_channel;
      repeat (3) @(posedge clk_sys);
      t = rnd();
      #1 conv_result = t[11:0];
      conv_done = 1'b1;
      res_q.push_back({cch, conv_result});
      @(posedge clk_sys);
      #1 conv_done = 1'b0;
    end
  end

  initial begin
    #900_000;
    err_total++;
    $display("CHECK FAILED t=%0t run timed out", $time);
    wrap_up();
  end

  initial begin
    clk_sys = 1'b0;
    sys_rst = 1'b1;
    convert_start_pin_n = 1'b1;
    conv_done = 1'b0;
    conv_result = 12'h000;
    seed = 32'h0000_D401;
    err_total = 0;
    cmp_count = 0;
    tg = 1'b0;
    repeat (16) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    chk(scan_mode, SCAN_RST, "scan reset");
    chk({power_state_select, tag_output_with_channel, software_convert_trigger,
         channel_pick, fifo_count}, 16'h0000, "fields reset");
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      r = rnd();
      ch = r[3:0];
      w = mode_word(SCAN_MANUAL, ch, RST_NONE, r[5:4], r[6], 1'b0) | {15'h0000, r[7]};
      fr(w);
      if (i > 0) chk(rd, out_word(tg, res_q.pop_front()), "manual word");
      chk({scan_mode, ch, r[5:4], r[6], 1'b0}, {SCAN_MANUAL, channel_pick, power_state_select,
          tag_output_with_channel, int_clock_mode}, "manual fields");
      tg = r[6];
    end
    $display("test manual done");
    r = rnd();
    fr({5'b00000, r[10:7], 2'b00, r[4:0]});
    chk({scan_mode, channel_pick, tag_output_with_channel, power_state_select,
         software_convert_trigger}, {SCAN_MANUAL, ch, tg, r[4:3], r[1]}, "null word");
    fr(mode_word(SCAN_REPEAT, ch, RST_NONE, 2'b00, 1'b0, 1'b0));
    @(posedge clk_sys);
    #1 convert_start_pin_n = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1 convert_start_pin_n = 1'b1;
    wait_fifo(REP);
    chk({int_clock_mode, conv_avg_allow}, 2'b11, "repeat clocking");
    fr(mode_word(SCAN_NULL, 4'h0, RST_FIFO, 2'b00, 1'b0, 1'b0));
    chk({scan_mode, fifo_count}, {SCAN_REPEAT, 5'h00}, "fifo clear");
    $display("test repeat done");
    res_q.delete();
    r = rnd();
    n = {1'b0, r[2:0]};
    fr(mode_word(SCAN_STDINT, n, RST_NONE, 2'b00, 1'b0, 1'b1));
    wait_fifo(n + 5'h01);
    chk(software_convert_trigger, 16'h0000, "trigger spent");
    for (int k = 0; k <= n; k++) chk(res_q[k][15:12], k[3:0], "scan order");
    fr(16'h8000);
    chk(rd, res_q[0], "internal tagged");
    chk(fifo_count, {1'b0, n}, "fifo read out");
    $display("test ascending done");
    fr(mode_word(SCAN_NULL, 4'h0, RST_ALL, 2'b00, 1'b0, 1'b0));
    chk({scan_mode, channel_pick, power_state_select, fifo_count},
        {SCAN_RST, CHAN_RST, PM_RST, 5'h00}, "reset all");
    fr(mode_word(SCAN_NULL, 4'h0, 2'b11, 2'b01, 1'b0, 1'b0));
    chk({scan_mode, power_state_select}, {SCAN_RST, 2'b01}, "unused reset");
    $display("test reset field done");
    wrap_up();
  end
endmodule

// ---- dv/amsc_host_model.sv ----
// Host controller model driving the four-wire link
`timescale 1ns/100ps
module amsc_host_model (
  output logic      sclk,
  output logic      cs_n,
  output logic      din,
  input  wire logic dout
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
  end
  // Clock stands still between frames; din flips so a stale level never passes
  task frame(input logic [15:0] w, output logic [15:0] rd);
    cs_n = 1'b0;
    #80;
    for (int k = 15; k >= 0; k--) begin
      din = w[k];
      #80 sclk = 1'b1;
      rd[k] = dout;
      #80 sclk = 1'b0;
    end
    #80 cs_n = 1'b1;
    din = ~din;
    #400;
  endtask
endmodule

// ---- dv/amsc_top_asserts.sv ----
// Concurrent checks on the mode and scan control ports
`timescale 1ns/100ps
module amsc_top_asserts
  import amsc_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  input wire logic       cs_n,
  input wire logic       conv_start,
  input wire logic [3:0] conv_channel,
  input wire logic       conv_avg_allow,
  input wire logic       int_clock_mode,
  input wire logic [1:0] power_state_select,
  input wire logic [3:0] scan_mode,
  input wire logic [3:0] channel_pick,
  input wire logic [4:0] fifo_count
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Eight idle cycles let a word taken at the last edge settle first
  sequence s_quiet; cs_n [*8]; endsequence
  sequence s_kick; conv_start ##1 !conv_start; endsequence
  property p_pulse; conv_start |-> s_kick; endproperty
  property p_held;
    s_quiet |=> $stable(scan_mode) && $stable(channel_pick) && $stable(power_state_select);
  endproperty
  property p_int;
    s_quiet |-> int_clock_mode == (scan_mode == SCAN_REPEAT || scan_mode == SCAN_STDINT);
  endproperty
  property p_avg;
    s_quiet |-> conv_avg_allow == (scan_mode == SCAN_REPEAT || scan_mode == SCAN_STDINT);
  endproperty
  property p_nonull; scan_mode != SCAN_NULL; endproperty
  property p_fifo; fifo_count <= DEPTH; endproperty
  property p_man;
    conv_start && scan_mode == SCAN_MANUAL |-> conv_channel == channel_pick;
  endproperty
  property p_rep;
    conv_start && scan_mode == SCAN_REPEAT |-> conv_channel == channel_pick;
  endproperty
  property p_asc;
    conv_start && scan_mode == SCAN_STDINT |-> conv_channel <= channel_pick;
  endproperty
  a_pulse: assert property (p_pulse) else $error("conv_start longer than one cycle");
  a_held: assert property (p_held) else $error("fields moved with no frame");
  a_int: assert property (p_int) else $error("clock mode wrong for scan");
  a_avg: assert property (p_avg) else $error("averaging permit wrong");
  a_nonull: assert property (p_nonull) else $error("null became active scan");
  a_fifo: assert property (p_fifo) else $error("fifo count over depth");
  a_man: assert property (p_man) else $error("manual channel wrong");
  a_rep: assert property (p_rep) else $error("repeat channel wrong");
  a_asc: assert property (p_asc) else $error("ascending channel past end");
endmodule
bind amsc_top amsc_top_asserts #(.DEPTH(DEPTH)) amsc_top_asserts_i (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .cs_n(cs_n), .conv_start(conv_start),
  .conv_channel(conv_channel), .conv_avg_allow(conv_avg_allow),
  .int_clock_mode(int_clock_mode), .power_state_select(power_state_select),
  .scan_mode(scan_mode), .channel_pick(channel_pick), .fifo_count(fifo_count));

// ---- rtl/amsc_edge_sync.sv ----
// Two-stage synchroniser with edge detection for one link pin
`timescale 1ns/100ps
module amsc_edge_sync
  import amsc_pkg::*;
#(
  // Idle level of the pin, so that leaving reset shows no false edge
  parameter logic IDLE = 1'b0
) (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic meta_r;
  logic sync_r;
  logic last_r;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      meta_r <= IDLE;
      sync_r <= IDLE;
      last_r <= IDLE;
    end else begin
      meta_r <= pin;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign level = sync_r;
  assign rise  = sync_r & ~last_r;
  assign fall  = ~sync_r & last_r;

endmodule

// ---- rtl/amsc_pkg.sv ----
// Package of constants and types for the converter mode and scan control block
package amsc_pkg;

  // ************************************************************
  // Word layout of the mode control word
  // ************************************************************
  localparam int WORD_W        = 16;
  localparam int SEL_BIT       = 15;
  localparam int SCAN_HI       = 14;
  localparam int SCAN_LO       = 11;
  localparam int CHAN_HI       = 10;
  localparam int CHAN_LO       = 7;
  localparam int RST_HI        = 6;
  localparam int RST_LO        = 5;
  localparam int PM_HI         = 4;
  localparam int PM_LO         = 3;
  localparam int TAG_BIT       = 2;
  localparam int SWT_BIT       = 1;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [3:0] SCAN_RST  = 4'h1;
  localparam logic [3:0] CHAN_RST  = 4'h0;
  localparam logic [1:0] PM_RST    = 2'h0;

  // ************************************************************
  // Codes
  // ************************************************************
  localparam logic [3:0] SCAN_NULL   = 4'h0;
  localparam logic [3:0] SCAN_MANUAL = 4'h1;
  localparam logic [3:0] SCAN_REPEAT = 4'h2;
  localparam logic [3:0] SCAN_STDINT = 4'h3;
  localparam logic [1:0] RST_NONE    = 2'h0;
  localparam logic [1:0] RST_FIFO    = 2'h1;
  localparam logic [1:0] RST_ALL     = 2'h2;

  // ************************************************************
  // Result words and FIFO
  // ************************************************************
  localparam int RES_W       = 12;
  localparam int FIFO_DEPTH  = 16;

  typedef enum logic [1:0] {
    AMSC_IDLE,
    AMSC_SHIFT,
    AMSC_DONE
  } amsc_frame_t;

endpackage

// ---- rtl/amsc_top.sv ----
// Mode control word decoder, scan sequencer and serial output framing
`timescale 1ns/100ps
module amsc_top
  import amsc_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH,
  parameter int REPEAT_COUNT = 4
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        din,
  input  wire logic        convert_start_pin_n,
  input  wire logic        conv_done,
  input  wire logic [11:0] conv_result,
  output logic             dout,
  output logic             conv_start,
  output logic [3:0]       conv_channel,
  output logic             conv_avg_allow,
  output logic             int_clock_mode,
  output logic [1:0]       power_state_select,
  output logic             tag_output_with_channel,
  output logic             software_convert_trigger,
  output logic [3:0]       scan_mode,
  output logic [3:0]       channel_pick,
  output logic [4:0]       fifo_count
);

  // FIFO pointers are four bits wide, so only a depth of sixteen is served
  if (DEPTH != 16 || (REPEAT_COUNT != 4 && REPEAT_COUNT != 8 &&
                      REPEAT_COUNT != 12 && REPEAT_COUNT != 16)) begin : g_bad_param
    $error("amsc_top: unsupported DEPTH or REPEAT_COUNT");
  end

  // ************************************************************
  // Link pin synchronisers
  // ************************************************************
  logic sclk_rise, sclk_fall, cs_lvl, cs_rise, cs_fall, cnv_fall, din_lvl;

  amsc_edge_sync u_sclk (.clk_sys(clk_sys), .sys_rst(sys_rst), .pin(sclk),
                         .level(), .rise(sclk_rise), .fall(sclk_fall));
  amsc_edge_sync #(.IDLE(1'b1)) u_cs (.clk_sys(clk_sys), .sys_rst(sys_rst), .pin(cs_n),
                         .level(cs_lvl), .rise(cs_rise), .fall(cs_fall));
  amsc_edge_sync #(.IDLE(1'b1)) u_cnv (.clk_sys(clk_sys), .sys_rst(sys_rst),
                         .pin(convert_start_pin_n),
                         .level(), .rise(), .fall(cnv_fall));
  amsc_edge_sync u_din  (.clk_sys(clk_sys), .sys_rst(sys_rst), .pin(din),
                         .level(din_lvl), .rise(), .fall());

  // ************************************************************
  // Frame shifter
  // ************************************************************
  amsc_frame_t     frame_r;
  logic [15:0]     shin_r;
  logic [15:0]     shout_r;
  logic [4:0]      bits_r;
  logic [3:0]      pend_chan_r;
  logic [11:0]     pend_res_r;

  wire in_frame   = ~cs_lvl;
  wire word_done  = (frame_r == AMSC_SHIFT) && sclk_rise && (bits_r == 5'd15);
  wire [15:0] word_in = {shin_r[14:0], din_lvl};
  wire is_mode_wr = word_done && (word_in[SEL_BIT] == 1'b0);
  wire [3:0] w_scan = word_in[SCAN_HI:SCAN_LO];
  wire [1:0] w_rst  = word_in[RST_HI:RST_LO];
  wire w_null = (w_scan == SCAN_NULL);

  // ************************************************************
  // Mode control word fields
  // ************************************************************
  wire  int_mode   = (scan_mode == SCAN_REPEAT) || (scan_mode == SCAN_STDINT);
  wire  rst_all    = is_mode_wr && (w_rst == RST_ALL);
  wire  rst_fifo   = is_mode_wr && (w_rst == RST_FIFO) || rst_all;
  wire  tag_now    = int_mode | tag_output_with_channel;
  wire  sw_fire    = int_mode && software_convert_trigger && cs_rise;
  wire  pin_fire   = int_mode && cnv_fall;

  always_ff @(posedge clk_sys) begin
    if (sys_rst || rst_all) begin
      scan_mode                <= SCAN_RST;
      channel_pick             <= CHAN_RST;
      power_state_select       <= PM_RST;
      tag_output_with_channel  <= 1'b0;
      software_convert_trigger <= 1'b0;
    end else if (is_mode_wr) begin
      if (!w_null) begin
        scan_mode    <= w_scan;
        channel_pick <= word_in[CHAN_HI:CHAN_LO];
        tag_output_with_channel <= word_in[TAG_BIT];
      end
      power_state_select       <= word_in[PM_HI:PM_LO];
      software_convert_trigger <= word_in[SWT_BIT];
    end else if (sw_fire) begin
      software_convert_trigger <= 1'b0;
    end
  end

  // ************************************************************
  // Sequencer and result FIFO
  // ************************************************************
  logic [11:0] fifo_r [DEPTH];
  logic [3:0]  fifo_chan_r [DEPTH];
  logic [3:0]  rd_r, wr_r;
  logic        busy_r;
  logic [4:0]  left_r;
  logic [3:0]  seq_chan_r;

  wire [4:0] scan_len = (scan_mode == SCAN_REPEAT) ? 5'(REPEAT_COUNT)
                                                   : {1'b0, channel_pick} + 5'd1;
  // A trigger that arrives while a scan runs is dropped, not queued
  wire start_scan  = (sw_fire || pin_fire) && !busy_r;
  wire push        = busy_r && conv_done && (fifo_count != 5'(DEPTH));
  wire pop         = word_done && (fifo_count != 5'd0) && int_mode;
  wire [3:0] next_chan = (scan_mode == SCAN_REPEAT) ? seq_chan_r : seq_chan_r + 4'd1;

  always_ff @(posedge clk_sys) begin
    if (sys_rst || rst_fifo) begin
      rd_r <= 4'h0; wr_r <= 4'h0; fifo_count <= 5'd0;
      for (int i = 0; i < DEPTH; i++) begin
        fifo_r[i] <= 12'h000; fifo_chan_r[i] <= 4'h0;
      end
    end else begin
      if (push) begin
        fifo_r[wr_r]      <= conv_result;
        fifo_chan_r[wr_r] <= conv_channel;
        wr_r              <= wr_r + 4'd1;
      end
      if (pop) rd_r <= rd_r + 4'd1;
      fifo_count <= fifo_count + 5'(push) - 5'(pop);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst || rst_all) begin
      busy_r <= 1'b0; left_r <= 5'd0; seq_chan_r <= 4'h0;
      conv_start <= 1'b0; conv_channel <= 4'h0;
      conv_avg_allow <= 1'b0; int_clock_mode <= 1'b0;
    end else begin
      int_clock_mode <= int_mode;
      conv_avg_allow <= int_mode;
      conv_start     <= 1'b0;
      if (start_scan) begin
        busy_r       <= 1'b1;
        left_r       <= scan_len;
        seq_chan_r   <= (scan_mode == SCAN_REPEAT) ? channel_pick : 4'h0;
        conv_channel <= (scan_mode == SCAN_REPEAT) ? channel_pick : 4'h0;
        conv_start   <= 1'b1;
      end else if (busy_r && conv_done) begin
        if (left_r == 5'd1) begin
          busy_r <= 1'b0;
        end else begin
          left_r       <= left_r - 5'd1;
          seq_chan_r   <= next_chan;
          conv_channel <= next_chan;
          conv_start   <= 1'b1;
        end
      end else if (is_mode_wr && (w_scan == SCAN_MANUAL)) begin
        // The word that enters manual mode already names its first channel
        conv_channel <= word_in[CHAN_HI:CHAN_LO];
        conv_start   <= 1'b1;
      end
    end
  end

  // Manual result held until the next frame loads it
  logic pend_load;
  assign pend_load = (scan_mode == SCAN_MANUAL) && conv_done && !busy_r;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pend_chan_r <= 4'h0; pend_res_r <= 12'h000;
    end else if (pend_load) begin
      pend_chan_r <= conv_channel;
      pend_res_r  <= conv_result;
    end
  end

  // ************************************************************
  // Frame timing and output word
  // ************************************************************
  wire [11:0] out_res  = int_mode ? fifo_r[rd_r] : pend_res_r;
  wire [3:0]  out_chan = int_mode ? fifo_chan_r[rd_r] : pend_chan_r;
  wire [15:0] out_word = tag_now ? {out_chan, out_res} : {out_res, 4'h0};

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      frame_r <= AMSC_IDLE; shin_r <= 16'h0000; shout_r <= 16'h0000;
      bits_r <= 5'd0; dout <= 1'b0;
    end else if (!in_frame) begin
      frame_r <= AMSC_IDLE;
      bits_r  <= 5'd0;
    end else if (cs_fall) begin
      frame_r <= AMSC_SHIFT;
      shout_r <= {out_word[14:0], 1'b0};
      dout    <= out_word[15];
    end else if (frame_r == AMSC_SHIFT) begin
      if (sclk_rise) begin
        shin_r <= word_in;
        bits_r <= bits_r + 5'd1;
        if (bits_r == 5'd15) frame_r <= AMSC_DONE;
      end
      if (sclk_fall) begin
        dout    <= shout_r[15];
        shout_r <= {shout_r[14:0], 1'b0};
      end
    end
  end

endmodule
